// ==== logic/ccs_ctrl.sv ====
/*
 * Comparator control and status logic with an AXI4-Lite register slave,
 * result synchroniser, edge flag, interrupt and analog settings outputs.
 * Assumes raw_compare_output_in is asynchronous to clk_in and the analog
 * core applies the settings it is given.
 */
// Local design decision: the AXI4-Lite slave port.
// Summary of operation
// R01: Bit 7 enables or disables the comparator
// R02: Margin bit picks small or large hysteresis
// R03: Bit 5 flag set on selected result edge
// R04: Flag uses synchronised result, so it lags
// R05: Writing 0 clears flag, 1 ignored
// R06: Bit 4 gates flag onto interrupt
// R07: Bit 3 reads synchronised result continuously
// R08: Result bit is 0 while disabled
// R09: Bit 2 lets result drive the pin
// R10: Sense 00/10 fall, 01 rise, 11 both
// R11: Select bits 7-6, 3-2 read zero
// R12: Bits 5-4 route the plus input
// R13: Low bits route the minus input
// R14: Flag holds until software clears it
// R15: Software sets inputs before enabling comparator
// R16: Interrupt high while flag and bit 4 set
`timescale 1ns/1ps
module ccs_ctrl
    import ccs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [11:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        raw_compare_output_in,
    output ccs_analog_s      analog_out,
    output logic             result_pin_out,
    output logic             result_pin_oe_out,
    output logic             edge_irq_out,
    output logic             irq_out
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic edge_hit(input logic [1:0] sense, input logic prev,
                                      input logic cur);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        case (sense)
            CCS_SENSE_RISE: edge_hit = rise;
            CCS_SENSE_BOTH: edge_hit = rise | fall;
            default:        edge_hit = fall;             // see R10
        endcase
    endfunction : edge_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        sync1_q, sync2_q, sync1_d, sync2_d;
    logic        result_q, result_d, prev_q, prev_d;
    logic        enable_q, enable_d, margin_q, margin_d;
    logic        flag_q, flag_d, irq_en_q, irq_en_d;
    logic        pin_en_q, pin_en_d;
    logic [1:0]  sense_q, sense_d;
    logic [7:0]  sel_q, sel_d;
    logic        st_q, st_d, mask_q, mask_d;
    logic        edge_ev;
    ccs_wstate_e wst_q, wst_d;
    logic [11:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awok_q, awok_d, wok_q, wok_d;
    logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        arrdy_q, arrdy_d, rvalid_q, rvalid_d;
    logic [1:0]  rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        pin_q, pin_d, pin_oe_q, pin_oe_d, eirq_q, eirq_d, irq_q, irq_d;
    ccs_analog_s analog_q, analog_d;
    logic [7:0]  cs_view;
    logic        wr_go, rd_go;

    // ------------------------------------------------------------------
    // Result synchroniser and edge detect
    // ------------------------------------------------------------------
    always_comb begin
        sync1_d  = raw_compare_output_in;
        sync2_d  = sync1_q;
        result_d = enable_q ? sync2_q : 1'b0;             // see R07 see R08
        prev_d   = result_q;
        edge_ev  = enable_q & edge_hit(sense_q, prev_q, result_q); // see R03 see R04
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            result_q <= 1'b0;
            prev_q   <= 1'b0;
        end else begin
            sync1_q  <= sync1_d;
            sync2_q  <= sync2_d;
            result_q <= result_d;
            prev_q   <= prev_d;
        end
    end

    assign cs_view = {enable_q, margin_q, flag_q, irq_en_q, result_q, pin_en_q, sense_q};
    assign wr_go   = (wst_q == CCS_W_EXEC);
    assign rd_go   = s_axi_arvalid_in & arrdy_q;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    always_comb begin
        wst_d    = wst_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        awok_d   = awok_q;
        wok_d    = wok_q;
        awrdy_d  = awrdy_q;
        wrdy_d   = wrdy_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        case (wst_q)
            CCS_W_IDLE: begin
                if (s_axi_awvalid_in & awrdy_q) begin
                    waddr_d = s_axi_awaddr_in;
                    awok_d  = 1'b1;
                    awrdy_d = 1'b0;
                end
                if (s_axi_wvalid_in & wrdy_q) begin
                    wdata_d = s_axi_wdata_in;
                    wstrb_d = s_axi_wstrb_in;
                    wok_d   = 1'b1;
                    wrdy_d  = 1'b0;
                end
                if ((awok_q | (s_axi_awvalid_in & awrdy_q)) &
                    (wok_q | (s_axi_wvalid_in & wrdy_q))) begin
                    wst_d = CCS_W_EXEC;
                end
            end
            CCS_W_EXEC: begin
                bresp_d  = (waddr_q == CCS_ADDR_CTRL_STATUS || waddr_q == CCS_ADDR_INPUT_SEL ||
                            waddr_q == CCS_ADDR_IRQ_STATUS || waddr_q == CCS_ADDR_IRQ_MASK)
                           ? CCS_RESP_OKAY : CCS_RESP_SLVERR;
                bvalid_d = 1'b1;
                wst_d    = CCS_W_RESP;
            end
            CCS_W_RESP: begin
                if (s_axi_bready_in) begin
                    bvalid_d = 1'b0;
                    awok_d   = 1'b0;
                    wok_d    = 1'b0;
                    awrdy_d  = 1'b1;
                    wrdy_d   = 1'b1;
                    wst_d    = CCS_W_IDLE;
                end
            end
            default: wst_d = CCS_W_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wst_q    <= CCS_W_IDLE;
            waddr_q  <= 12'h000;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            awok_q   <= 1'b0;
            wok_q    <= 1'b0;
            awrdy_q  <= 1'b1;
            wrdy_q   <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q  <= CCS_RESP_OKAY;
        end else begin
            wst_q    <= wst_d;
            waddr_q  <= waddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            awok_q   <= awok_d;
            wok_q    <= wok_d;
            awrdy_q  <= awrdy_d;
            wrdy_q   <= wrdy_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers, flag, interrupt status
    // ------------------------------------------------------------------
    always_comb begin
        enable_d = enable_q;
        margin_d = margin_q;
        irq_en_d = irq_en_q;
        pin_en_d = pin_en_q;
        sense_d  = sense_q;
        sel_d    = sel_q;
        mask_d   = mask_q;
        flag_d   = flag_q;                                 // see R14
        st_d     = st_q;
        if (wr_go && wstrb_q[0]) begin
            if (waddr_q == CCS_ADDR_CTRL_STATUS) begin
                enable_d = wdata_q[CCS_BIT_ENABLE];        // see R01
                margin_d = wdata_q[CCS_BIT_MARGIN];        // see R02
                irq_en_d = wdata_q[CCS_BIT_IRQ_EN];        // see R06
                pin_en_d = wdata_q[CCS_BIT_PIN_EN];        // see R09
                sense_d  = wdata_q[CCS_SENSE_LSB +: 2];
                if (!wdata_q[CCS_BIT_FLAG]) begin
                    flag_d = 1'b0;                         // see R05
                end
            end
            if (waddr_q == CCS_ADDR_INPUT_SEL) begin
                sel_d = wdata_q[7:0] & CCS_SEL_WMASK;      // see R11
            end
            if (waddr_q == CCS_ADDR_IRQ_MASK) begin
                mask_d = wdata_q[CCS_BIT_ST_EDGE];
            end
        end
        if (rd_go && s_axi_araddr_in == CCS_ADDR_IRQ_STATUS) begin
            st_d = 1'b0;
        end
        if (edge_ev) begin
            flag_d = 1'b1;                                 // see R03
            st_d   = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_q <= CCS_CS_RESET[CCS_BIT_ENABLE];
            margin_q <= CCS_CS_RESET[CCS_BIT_MARGIN];
            flag_q   <= CCS_CS_RESET[CCS_BIT_FLAG];
            irq_en_q <= CCS_CS_RESET[CCS_BIT_IRQ_EN];
            pin_en_q <= CCS_CS_RESET[CCS_BIT_PIN_EN];
            sense_q  <= CCS_CS_RESET[CCS_SENSE_LSB +: 2];
            sel_q    <= CCS_SEL_RESET;
            st_q     <= 1'b0;
            mask_q   <= 1'b0;
        end else begin
            enable_q <= enable_d;
            margin_q <= margin_d;
            flag_q   <= flag_d;
            irq_en_q <= irq_en_d;
            pin_en_q <= pin_en_d;
            sense_q  <= sense_d;
            sel_q    <= sel_d;
            st_q     <= st_d;
            mask_q   <= mask_d;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel and registered outputs
    // ------------------------------------------------------------------
    always_comb begin
        arrdy_d  = arrdy_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (rd_go) begin
            arrdy_d  = 1'b0;
            rvalid_d = 1'b1;
            rresp_d  = CCS_RESP_OKAY;
            case (s_axi_araddr_in)
                CCS_ADDR_CTRL_STATUS: rdata_d = {24'h000000, cs_view};
                CCS_ADDR_INPUT_SEL:   rdata_d = {24'h000000, sel_q};   // see R11
                CCS_ADDR_IRQ_STATUS:  rdata_d = {31'h00000000, st_q};
                CCS_ADDR_IRQ_MASK:    rdata_d = {31'h00000000, mask_q};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = CCS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_d = 1'b0;
            arrdy_d  = 1'b1;
        end
        analog_d.enable       = enable_q;                 // see R01
        analog_d.margin_large = margin_q;                 // see R02
        analog_d.plus_sel     = sel_q[CCS_PLUS_LSB +: 2]; // see R12
        analog_d.minus_sel    = sel_q[CCS_MINUS_LSB +: 2]; // see R13
        pin_d    = result_q & pin_en_q;                   // see R09
        pin_oe_d = pin_en_q;
        eirq_d   = flag_q & irq_en_q;                     // see R16
        irq_d    = st_q & mask_q;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            arrdy_q  <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q  <= CCS_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            analog_q <= '0;
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
            eirq_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            arrdy_q  <= arrdy_d;
            rvalid_q <= rvalid_d;
            rresp_q  <= rresp_d;
            rdata_q  <= rdata_d;
            analog_q <= analog_d;
            pin_q    <= pin_d;
            pin_oe_q <= pin_oe_d;
            eirq_q   <= eirq_d;
            irq_q    <= irq_d;
        end
    end

    assign s_axi_awready_out = awrdy_q;
    assign s_axi_wready_out  = wrdy_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;
    assign s_axi_arready_out = arrdy_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rresp_out   = rresp_q;
    assign s_axi_rdata_out   = rdata_q;
    assign analog_out        = analog_q;
    assign result_pin_out    = pin_q;
    assign result_pin_oe_out = pin_oe_q;
    assign edge_irq_out      = eirq_q;
    assign irq_out           = irq_q;

endmodule : ccs_ctrl

// ==== common/ccs_pkg.sv ====
/*
 * Package for the comparator control and status block: register indices,
 * field positions, reset values and shared types.
 * Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
 */
package ccs_pkg;

    // ------------------------------------------------------------------
    // Register map (printed offsets are indices; byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0]  CCS_IDX_CTRL_STATUS = 8'h2C;
    localparam logic [7:0]  CCS_IDX_INPUT_SEL   = 8'h2D;
    localparam logic [7:0]  CCS_IDX_IRQ_STATUS  = 8'h30;
    localparam logic [7:0]  CCS_IDX_IRQ_MASK    = 8'h31;
    localparam logic [11:0] CCS_ADDR_CTRL_STATUS = {2'h0, CCS_IDX_CTRL_STATUS, 2'h0};
    localparam logic [11:0] CCS_ADDR_INPUT_SEL   = {2'h0, CCS_IDX_INPUT_SEL, 2'h0};
    localparam logic [11:0] CCS_ADDR_IRQ_STATUS  = {2'h0, CCS_IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] CCS_ADDR_IRQ_MASK    = {2'h0, CCS_IDX_IRQ_MASK, 2'h0};

    // ------------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------------
    localparam int CCS_BIT_ENABLE     = 7;
    localparam int CCS_BIT_MARGIN     = 6;
    localparam int CCS_BIT_FLAG       = 5;
    localparam int CCS_BIT_IRQ_EN     = 4;
    localparam int CCS_BIT_RESULT     = 3;
    localparam int CCS_BIT_PIN_EN     = 2;
    localparam int CCS_SENSE_LSB      = 0;
    localparam int CCS_PLUS_LSB       = 4;
    localparam int CCS_MINUS_LSB      = 0;
    localparam int CCS_BIT_ST_EDGE    = 0;

    localparam logic [7:0] CCS_CS_RESET   = 8'h00;
    localparam logic [7:0] CCS_SEL_RESET  = 8'h00;
    localparam logic [7:0] CCS_SEL_WMASK  = 8'h33;

    // Edge sense codes
    localparam logic [1:0] CCS_SENSE_FALL  = 2'h0;
    localparam logic [1:0] CCS_SENSE_RISE  = 2'h1;
    localparam logic [1:0] CCS_SENSE_FALL2 = 2'h2;
    localparam logic [1:0] CCS_SENSE_BOTH  = 2'h3;

    // Input select codes
    localparam logic [1:0] CCS_IN_EXT0 = 2'h0;
    localparam logic [1:0] CCS_IN_EXT1 = 2'h1;
    localparam logic [1:0] CCS_IN_RSVD = 2'h2;
    localparam logic [1:0] CCS_IN_DAC  = 2'h3;

    localparam logic [1:0] CCS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CCS_RESP_SLVERR = 2'h2;

    // Settings driven to the analog core
    typedef struct packed {
        logic       enable;
        logic       margin_large;
        logic [1:0] plus_sel;
        logic [1:0] minus_sel;
    } ccs_analog_s;

    // Write channel state
    typedef enum logic [2:0] {
        CCS_W_IDLE = 3'b001,
        CCS_W_EXEC = 3'b010,
        CCS_W_RESP = 3'b100
    } ccs_wstate_e;

endpackage : ccs_pkg

// ==== verif/ccs_cmp_model.sv ====
/* Behavioural analog comparator core for the ccs_ctrl bench.
   Assumes the bench holds level_in steady while the core is disabled. */
`timescale 1ns/1ps
module ccs_cmp_model
    import ccs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire ccs_analog_s set_in,
    input  wire logic        level_in,
    output logic             raw_out
);
    // Unpowered core shows the inverse of level_in
    always_ff @(posedge clk_in) begin
        raw_out <= set_in.enable ? level_in : ~level_in;
    end
endmodule : ccs_cmp_model

// ==== verif/ccs_ctrl_sva.sv ====
/* Port checker for ccs_ctrl.
   Bound to ccs_ctrl from the bench top; sees only its ports. */
`timescale 1ns/1ps
module ccs_ctrl_sva
    import ccs_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_rvalid_out,
    input wire logic        raw_compare_output_in,
    input wire ccs_analog_s analog_out,
    input wire logic        result_pin_out,
    input wire logic        result_pin_oe_out,
    input wire logic        edge_irq_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_oe;
        result_pin_out |-> result_pin_oe_out;
    endproperty
    property p_off;
        (!analog_out.enable) [*3] |-> !result_pin_out;
    endproperty
    property p_lag;
        $rose(result_pin_out) && $stable(result_pin_oe_out)
            |-> $past(raw_compare_output_in, 4);
    endproperty
    property p_evt;
        $rose(edge_irq_out) && !$past(s_axi_bvalid_out)
            |-> $past(raw_compare_output_in, 5) != $past(raw_compare_output_in, 6);
    endproperty
    property p_hold;
        edge_irq_out && !s_axi_bvalid_out |=> edge_irq_out;
    endproperty
    property p_clr;
        $fell(edge_irq_out) |-> $past(s_axi_bvalid_out) || $past(rst_in);
    endproperty
    property p_irq;
        irq_out && !s_axi_rvalid_out && !$past(s_axi_arvalid_in) && !s_axi_bvalid_out
            |=> irq_out;
    endproperty
    property p_ana;
        $changed(analog_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin driven while pin enable low");
    a_off: assert property (p_off)
        else $error("result seen while disabled");
    a_lag: assert property (p_lag)
        else $error("pin rose without synchronised input");
    a_evt: assert property (p_evt)
        else $error("edge interrupt without input edge");
    a_hold: assert property (p_hold)
        else $error("edge interrupt dropped without write");
    a_clr: assert property (p_clr)
        else $error("edge interrupt fell without write");
    a_irq: assert property (p_irq)
        else $error("interrupt line dropped without access");
    a_ana: assert property (p_ana)
        else $error("analog settings changed without write");
    c_evt: cover property ($rose(edge_irq_out));
    c_irq: cover property ($rose(irq_out));
    c_pin: cover property ($rose(result_pin_out));
endmodule : ccs_ctrl_sva

// ==== verif/comparator_control_status_tb.sv ====
/* Self-checking bench for ccs_ctrl over AXI4-Lite.
   Assumes ccs_cmp_model on the analog side and ccs_ctrl_sva bound. */
`timescale 1ns/1ps
module comparator_control_status_tb
    import ccs_pkg::*;
;
    logic        clk_in, rst_in, lvl, ie, pe, mk, f;
    logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in;
    logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_rready_in, raw_compare_output_in;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic        s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    ccs_analog_s analog_out;
    logic        result_pin_out, result_pin_oe_out, edge_irq_out, irq_out;
    logic [7:0]  s, c;
    int          errors, checked, cyc;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];

    ccs_ctrl dut_u (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .raw_compare_output_in,
        .analog_out, .result_pin_out, .result_pin_oe_out, .edge_irq_out, .irq_out);
    ccs_cmp_model cmp_u (.clk_in, .set_in(analog_out), .level_in(lvl),
        .raw_out(raw_compare_output_in));

    initial begin
        clk_in = 0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task automatic chk_rd(input logic [33:0] g, input logic [33:0] e);
        cmp(g, e);
    endtask : chk_rd
    task automatic chk_br(input logic [1:0] g, input logic [1:0] e);
        cmp({32'h0, g}, {32'h0, e});
    endtask : chk_br
    task automatic chk_out(input logic [3:0] g, input logic [3:0] e);
        cmp({30'h0, g}, {30'h0, e});
    endtask : chk_out

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r = CCS_RESP_OKAY);
        logic ad, wd;
        @(posedge clk_in);
        bq.push_back(r);
        ad = 0;
        wd = 0;
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_awvalid_in <= 1;
        s_axi_wvalid_in <= 1;
        s_axi_bready_in <= 1;
        while (!(ad && wd)) begin
            @(posedge clk_in);
            if (!ad && s_axi_awready_out) begin
                ad = 1;
                s_axi_awvalid_in <= 0;
            end
            if (!wd && s_axi_wready_out) begin
                wd = 1;
                s_axi_wvalid_in <= 0;
            end
        end
        while (!s_axi_bvalid_out) @(posedge clk_in);
        s_axi_bready_in <= 0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] r = CCS_RESP_OKAY);
        @(posedge clk_in);
        rq.push_back({r, 24'h0, d});
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1;
        s_axi_rready_in <= 1;
        do @(posedge clk_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 0;
        do @(posedge clk_in); while (!s_axi_rvalid_out);
        s_axi_rready_in <= 0;
    endtask : rd

    always @(posedge clk_in) begin
        if (s_axi_bvalid_out && s_axi_bready_in)
            chk_br(s_axi_bresp_out, bq.pop_front());
        if (s_axi_rvalid_out && s_axi_rready_in)
            chk_rd({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
        cyc++;
        if (cyc == 20000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        errors = 0; checked = 0; cyc = 0; lvl = 0; rst_in = 1;
        s_axi_awaddr_in = 0; s_axi_araddr_in = 0; s_axi_wdata_in = 0;
        s_axi_wstrb_in = 4'hF; s_axi_awvalid_in = 0; s_axi_wvalid_in = 0;
        s_axi_bready_in = 0; s_axi_arvalid_in = 0; s_axi_rready_in = 0;
        void'($urandom(21444));
        repeat (4) @(posedge clk_in);
        rst_in <= 0;
        rd(CCS_ADDR_CTRL_STATUS, 8'h00);
        rd(12'h0FC, 8'h00, CCS_RESP_SLVERR);
        wr(12'h0FC, 8'hFF, CCS_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            s = 8'($urandom);
            s[5:4] = i[1:0];
            s[1:0] = 2'(3 - i);
            wr(CCS_ADDR_INPUT_SEL, s);
            rd(CCS_ADDR_INPUT_SEL, s & 8'h33);
            chk_out({analog_out.plus_sel, analog_out.minus_sel}, {s[5:4], s[1:0]});
        end
        // First enable sees stale high then low: one falling edge
        wr(CCS_ADDR_CTRL_STATUS, 8'hC0);
        repeat (10) @(posedge clk_in);
        chk_out({2'h0, analog_out.enable, analog_out.margin_large}, 4'h3);
        rd(CCS_ADDR_CTRL_STATUS, 8'hE0);
        rd(CCS_ADDR_IRQ_STATUS, 8'h01);
        rd(CCS_ADDR_IRQ_STATUS, 8'h00);
        wr(CCS_ADDR_CTRL_STATUS, 8'h80);
        rd(CCS_ADDR_CTRL_STATUS, 8'h80);
        // Low byte lane off: write must be ignored
        s_axi_wstrb_in <= 4'hE;
        wr(CCS_ADDR_CTRL_STATUS, 8'h00);
        s_axi_wstrb_in <= 4'hF;
        rd(CCS_ADDR_CTRL_STATUS, 8'h80);
        for (int m = 0; m < 4; m++) begin
            ie = (m != 3);
            pe = !m[0];
            mk = (m != 2);
            f = m[0];
            c = {3'b100, ie, 1'b0, pe, m[1:0]};
            wr(CCS_ADDR_IRQ_MASK, {7'h0, mk});
            wr(CCS_ADDR_CTRL_STATUS, c | 8'h20);
            rd(CCS_ADDR_CTRL_STATUS, c);
            lvl <= 1;
            repeat (10) @(posedge clk_in);
            chk_out({result_pin_out, result_pin_oe_out, edge_irq_out, irq_out},
                    {pe, pe, f & ie, f & mk});
            rd(CCS_ADDR_CTRL_STATUS, c | 8'h08 | {2'h0, f, 5'h0});
            lvl <= 0;
            repeat (10) @(posedge clk_in);
            chk_out({result_pin_out, result_pin_oe_out, edge_irq_out, irq_out},
                    {1'b0, pe, ie, mk});
            rd(CCS_ADDR_CTRL_STATUS, c | 8'h20);
            rd(CCS_ADDR_IRQ_STATUS, 8'h01);
            wr(CCS_ADDR_CTRL_STATUS, c);
            repeat (3) @(posedge clk_in);
            chk_out({1'b0, result_pin_oe_out, edge_irq_out, irq_out}, {1'b0, pe, 2'h0});
        end
        // Mid-run reset while enabled with result and flag high
        lvl <= 1;
        repeat (10) @(posedge clk_in);
        rst_in <= 1;
        repeat (4) @(posedge clk_in);
        rst_in <= 0;
        rd(CCS_ADDR_CTRL_STATUS, 8'h00);
        rd(CCS_ADDR_INPUT_SEL, 8'h00);
        rd(CCS_ADDR_IRQ_STATUS, 8'h00);
        wr(CCS_ADDR_CTRL_STATUS, 8'h00);
        repeat (10) @(posedge clk_in);
        rd(CCS_ADDR_CTRL_STATUS, 8'h00);
        rd(CCS_ADDR_IRQ_STATUS, 8'h00);
        chk_out({2'h0, analog_out.enable, analog_out.margin_large}, 4'h0);
        test_done();
    end
endmodule : comparator_control_status_tb

bind ccs_ctrl ccs_ctrl_sva chk_u (.clk_in, .rst_in, .s_axi_bvalid_out, .s_axi_arvalid_in,
    .s_axi_rvalid_out, .raw_compare_output_in, .analog_out, .result_pin_out,
    .result_pin_oe_out, .edge_irq_out, .irq_out);
